// ===== common/dev_ctrl_pkg.sv
// Package for the express device control register bank.
// Assumes one configuration clock; offsets are byte addresses in config space.
package dev_ctrl_pkg;

  // Register location and layout
  localparam logic [11:0] DEVCTL_OFFSET        = 12'h048;
  localparam logic [15:0] DEVCTL_RESET         = 16'h0000;
  localparam int          BIT_RSVD15           = 15;
  localparam int          RDREQ_MSB            = 14;
  localparam int          RDREQ_LSB            = 12;
  localparam int          BIT_NOSNOOP_EN       = 11;
  localparam int          BIT_AUXPM_EN         = 10;
  localparam int          BIT_PHANTOM_EN       = 9;
  localparam int          BIT_EXT_TAG_EN       = 8;
  localparam int          PAYLOAD_MSB          = 7;
  localparam int          PAYLOAD_LSB          = 5;
  localparam int          BIT_RELAX_EN         = 4;
  localparam int          BIT_UR_REPORT_EN     = 3;
  localparam int          BIT_FATAL_REPORT_EN  = 2;
  localparam int          BIT_NONFATAL_EN      = 1;
  localparam int          BIT_CORR_EN          = 0;

  // Writable bits; 15, 10 and 9 are held at zero
  localparam logic [15:0] DEVCTL_WMASK         = 16'h79ff;

  // Payload encodings and limits in bytes
  localparam logic [2:0]  PAYLOAD_128          = 3'h0;
  localparam logic [2:0]  PAYLOAD_256          = 3'h1;
  localparam logic [12:0] BYTES_128            = 13'h0080;
  localparam logic [12:0] BYTES_256            = 13'h0100;

  // Number of functions sharing the block
  localparam int          NUM_FUNC             = 3;

  // Outbound DMA request attributes
  typedef struct packed {
    logic no_snoop;
    logic relaxed;
  } tlp_attr_s;

  // Error events from a port
  typedef struct packed {
    logic ur;
    logic fatal;
    logic internal_fatal;
  } err_evt_s;

endpackage

// ===== design/dev_ctrl_bank.sv
// Express device control register, one copy per function, plus its gating.
// Assumes config accesses are single-cycle strobes in the configuration clock.
//
// Contract
// - Read request size field is ignored
// - Snoop-free enable clear: DMA stays snooped
// - Snoop-free enable set: driver may request
// - Root port own requests never snoop-free
// - Forwarded snoop attribute passes unchanged
// - Relaxed enable clear: DMA strictly ordered
// - Relaxed enable set: driver may relax
// - Root port own requests never relaxed
// - Forwarded relaxed attribute passes unchanged
// - Payload 001 is 256B only on express
// - Accept inbound payload up to limit
// - Own outbound payload never above limit; longer own requests are only flagged on o_req_len_err, not blocked
// - Bit 8 enables 8-bit requester tags
// - Phantom function enable has no effect
// - Auxiliary power enable held at zero
// - Bit 3 gates unsupported request reporting
// - Bit 2 gates fatal error reporting
// - Internal fatal errors ignore bit 2
`timescale 1ns/1ns
`default_nettype none

module dev_ctrl_bank #(
  parameter int NF = dev_ctrl_pkg::NUM_FUNC
) (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  // Configuration access
  input  wire logic [1:0]                    i_cfg_func,
  input  wire logic [11:0]                   i_cfg_addr,
  input  wire logic                          i_cfg_wr,
  input  wire logic                          i_cfg_rd,
  input  wire logic [1:0]                    i_cfg_be,
  input  wire logic [15:0]                   i_cfg_wdata,
  output logic      [15:0]                   o_cfg_rdata,
  output logic                               o_cfg_rvalid,
  // Per function: 1 = standard express port, 0 = DMA / chipset link
  input  wire logic [NF-1:0]                 i_is_express,
  // Outbound requests per function
  input  wire logic [NF-1:0]                 i_req_valid,
  input  wire logic [NF-1:0]                 i_req_forwarded,
  input  wire logic [NF-1:0]                 i_req_is_dma,
  input  wire dev_ctrl_pkg::tlp_attr_s [NF-1:0] i_req_attr,
  input  wire logic [NF-1:0][12:0]           i_req_len,
  output dev_ctrl_pkg::tlp_attr_s [NF-1:0]   o_req_attr,
  output logic      [NF-1:0]                 o_req_len_err,
  output logic      [NF-1:0]                 o_ext_tag_en,
  output logic      [NF-1:0][12:0]           o_payload_limit,
  // Inbound payload check
  input  wire logic [NF-1:0]                 i_rx_valid,
  input  wire logic [NF-1:0][12:0]           i_rx_len,
  output logic      [NF-1:0]                 o_rx_accept,
  // Error events and reports
  input  wire dev_ctrl_pkg::err_evt_s [NF-1:0] i_err,
  output logic      [NF-1:0]                 o_report_ur,
  output logic      [NF-1:0]                 o_report_fatal
);
  import dev_ctrl_pkg::*;

  logic [NF-1:0][15:0] ctl_q, ctl_d;
  logic [15:0]         rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d;
  logic                hit;

  tlp_attr_s [NF-1:0]   attr_q, attr_d;
  logic [NF-1:0]        len_err_q, len_err_d;
  logic [NF-1:0]        tag_q, tag_d;
  logic [NF-1:0][12:0]  lim_q, lim_d;
  logic [NF-1:0]        acc_q, acc_d;
  logic [NF-1:0]        ur_q, ur_d;
  logic [NF-1:0]        fat_q, fat_d;

  assign hit = (i_cfg_addr == DEVCTL_OFFSET) && (32'(i_cfg_func) < NF);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads
  always_comb begin
    logic [15:0] m;
    m        = '0;
    ctl_d    = ctl_q;
    rdata_d  = '0;
    rvalid_d = i_cfg_rd;
    m = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}} & DEVCTL_WMASK;
    if (i_cfg_wr && hit) begin
      ctl_d[i_cfg_func] = (ctl_q[i_cfg_func] & ~m) | (i_cfg_wdata & m);
    end
    if (i_cfg_rd && hit) begin
      rdata_d = ctl_q[i_cfg_func] & DEVCTL_WMASK; // Unmapped reads give zero
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q    <= {NF{DEVCTL_RESET}};
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      ctl_q    <= ctl_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-function gating; read request field is never consulted
  always_comb begin
    for (int f = 0; f < NF; f++) begin
      logic [15:0] c;
      logic        own_dma;
      c       = ctl_q[f];
      own_dma = i_req_is_dma[f] && !i_req_forwarded[f];
      // Payload limit: 256B only for express ports
      if (c[PAYLOAD_MSB:PAYLOAD_LSB] == PAYLOAD_256 && i_is_express[f]) begin
        lim_d[f] = BYTES_256;
      end else begin
        lim_d[f] = BYTES_128;
      end
      // Attributes
      if (i_req_forwarded[f]) begin
        attr_d[f] = i_req_attr[f];
      end else if (own_dma) begin
        attr_d[f].no_snoop = i_req_attr[f].no_snoop && c[BIT_NOSNOOP_EN];
        attr_d[f].relaxed  = i_req_attr[f].relaxed && c[BIT_RELAX_EN];
      end else begin
        attr_d[f] = '0;
      end
      len_err_d[f] = i_req_valid[f] && !i_req_forwarded[f]
                     && (i_req_len[f] > lim_d[f]);
      acc_d[f] = i_rx_valid[f] && (i_rx_len[f] <= lim_d[f]);
      tag_d[f] = c[BIT_EXT_TAG_EN];
      ur_d[f]  = i_err[f].ur && c[BIT_UR_REPORT_EN];
      fat_d[f] = (i_err[f].fatal && c[BIT_FATAL_REPORT_EN])
                 || i_err[f].internal_fatal;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      attr_q    <= '0;
      len_err_q <= '0;
      tag_q     <= '0;
      lim_q     <= {NF{BYTES_128}};
      acc_q     <= '0;
      ur_q      <= '0;
      fat_q     <= '0;
    end else begin
      attr_q    <= attr_d;
      len_err_q <= len_err_d;
      tag_q     <= tag_d;
      lim_q     <= lim_d;
      acc_q     <= acc_d;
      ur_q      <= ur_d;
      fat_q     <= fat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign o_cfg_rdata     = rdata_q;
  assign o_cfg_rvalid    = rvalid_q;
  assign o_req_attr      = attr_q;
  assign o_req_len_err   = len_err_q;
  assign o_ext_tag_en    = tag_q;
  assign o_payload_limit = lim_q;
  assign o_rx_accept     = acc_q;
  assign o_report_ur     = ur_q;
  assign o_report_fatal  = fat_q;

endmodule

`default_nettype wire

// ===== dv/dev_ctrl_checker.sv
// Checker for the device control bank.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module dev_ctrl_checker #(
  parameter int NF = dev_ctrl_pkg::NUM_FUNC
) (
  input wire logic                            i_sys_clk,
  input wire logic                            i_rst_n,
  input wire logic                            i_cfg_rd,
  input wire logic                            o_cfg_rvalid,
  input wire logic [15:0]                     o_cfg_rdata,
  input wire logic [NF-1:0]                   i_req_valid,
  input wire logic [NF-1:0]                   i_req_forwarded,
  input wire logic [NF-1:0]                   i_req_is_dma,
  input wire dev_ctrl_pkg::tlp_attr_s [NF-1:0] i_req_attr,
  input wire dev_ctrl_pkg::tlp_attr_s [NF-1:0] o_req_attr,
  input wire logic [NF-1:0][12:0]             o_payload_limit,
  input wire logic [NF-1:0]                   i_rx_valid,
  input wire logic [NF-1:0][12:0]             i_rx_len,
  input wire logic [NF-1:0]                   o_rx_accept,
  input wire dev_ctrl_pkg::err_evt_s [NF-1:0] i_err,
  input wire logic [NF-1:0]                   o_report_ur,
  input wire logic [NF-1:0]                   o_report_fatal
);
  import dev_ctrl_pkg::*;
  ////////////////////////////////////////
  // One clock domain for all properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  rd_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid) else $error("read answer missing");
  held_zero_a: assert property (o_cfg_rvalid |-> (o_cfg_rdata & ~DEVCTL_WMASK) == 16'h0000)
    else $error("held bits read nonzero");
  root_attr_a: assert property (i_req_valid[0] && !i_req_forwarded[0] && !i_req_is_dma[0]
    |=> o_req_attr[0] == 2'h0) else $error("own root request carries attribute");
  fwd_attr_a: assert property (i_req_valid[0] && i_req_forwarded[0]
    |=> o_req_attr[0] == $past(i_req_attr[0])) else $error("forwarded attribute altered");
  dma_attr_a: assert property (i_req_valid[0] && i_req_is_dma[0] && !i_req_forwarded[0]
    |=> (o_req_attr[0] & ~$past(i_req_attr[0])) == 2'h0) else $error("unrequested attribute");
  limit_val_a: assert property (o_payload_limit[1] == BYTES_128 || o_payload_limit[1] == BYTES_256)
    else $error("bad payload limit");
  rx_accept_a: assert property (1'b1 |=> o_rx_accept[1] ==
    ($past(i_rx_valid[1]) && $past(i_rx_len[1]) <= o_payload_limit[1])) else $error("rx accept wrong");
  ur_gate_a: assert property (!i_err[0].ur |=> !o_report_ur[0]) else $error("ur report uncaused");
  fatal_gate_a: assert property (!i_err[0].fatal && !i_err[0].internal_fatal |=> !o_report_fatal[0])
    else $error("fatal report uncaused");
  int_fatal_a: assert property (i_err[0].internal_fatal |=> o_report_fatal[0])
    else $error("internal fatal not reported");
endmodule
bind dev_ctrl_bank dev_ctrl_checker #(.NF(NF)) chk (.*);
`default_nettype wire

// ===== dv/pcie_device_control_reg_bench.sv
// Self-checking bench for the device control bank.
// Assumes the checker is bound in; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module pcie_device_control_reg_bench;
  import dev_ctrl_pkg::*;
  typedef struct packed {logic [15:0] w; tlp_attr_s a; logic d; logic f; tlp_attr_s e;} row_s;
  logic             sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rvalid;
  logic [1:0]       func = 2'h0, be = 2'h3;
  logic [11:0]      addr = DEVCTL_OFFSET;
  logic [15:0]      wdata = 16'h0000, rdata;
  logic [2:0]       expr = 3'h2, req_v = 3'h0, fwd = 3'h0, dma = 3'h0, rx_v = 3'h0;
  logic [2:0]       len_err, xtag, acc, rep_ur, rep_fat;
  tlp_attr_s [2:0]  attr = '0, attr_o;
  err_evt_s [2:0]   err = '0;
  logic [2:0][12:0] len = '0, rx_len = '0, limit;
  int               n_mismatch = 0, tests_run = 0;
  row_s             rows [6] = '{'{16'h0000, 2'h3, 1'b1, 1'b0, 2'h0}, '{16'h0810, 2'h3, 1'b1, 1'b0, 2'h3},
    '{16'h0800, 2'h3, 1'b1, 1'b0, 2'h2}, '{16'h0810, 2'h3, 1'b0, 1'b0, 2'h0},
    '{16'h0000, 2'h3, 1'b0, 1'b1, 2'h3}, '{16'h0810, 2'h1, 1'b1, 1'b0, 2'h1}};
  dev_ctrl_bank dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cfg_func(func), .i_cfg_addr(addr),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .i_is_express(expr), .i_req_valid(req_v), .i_req_forwarded(fwd),
    .i_req_is_dma(dma), .i_req_attr(attr), .i_req_len(len), .o_req_attr(attr_o), .o_req_len_err(len_err),
    .o_ext_tag_en(xtag), .o_payload_limit(limit), .i_rx_valid(rx_v), .i_rx_len(rx_len),
    .o_rx_accept(acc), .i_err(err), .o_report_ur(rep_ur), .o_report_fatal(rep_fat));
  ////////////////////////////////////////
  // Clock, 4 ns period
  always #2 sys_clk = ~sys_clk;
  task automatic cyc(int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wreg(logic [1:0] f, logic [15:0] d);
    func = f; wdata = d; wr = 1'b1; cyc();
    wr = 1'b0; cyc();
  endtask
  task automatic rreg(logic [1:0] f, logic [15:0] e);
    func = f; rd = 1'b1; cyc();
    rd = 1'b0; `CHK(rvalid, 1'b1) `CHK(rdata, e)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog, far beyond the 47 cycles the tests take
  initial begin
    #20000 n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial begin
    cyc(8); rst_n = 1'b1; `CHK(limit[0], BYTES_128)
    rreg(2'h0, 16'h0000);
    $display("test reset done");
    foreach (rows[k]) begin
      wreg(2'h0, rows[k].w); attr[0] = rows[k].a; dma[0] = rows[k].d; fwd[0] = rows[k].f; req_v[0] = 1'b1; cyc();
      `CHK(attr_o[0], rows[k].e)
      req_v[0] = 1'b0;
    end
    $display("test rows done");
    wreg(2'h0, 16'hffff); rreg(2'h0, 16'h79ff);
    `CHK(xtag[0], 1'b1)
    `CHK(limit[0], BYTES_128)
    rreg(2'h3, 16'h0000);
    be = 2'h1; wreg(2'h0, 16'h0000); be = 2'h3;
    rreg(2'h0, 16'h7900);
    $display("test regs done");
    wreg(2'h1, 16'h0020); `CHK(limit[1], BYTES_256)
    wreg(2'h0, 16'h0020); `CHK(limit[0], BYTES_128)
    rx_v[1] = 1'b1; rx_len[1] = 13'h0100; len[1] = 13'h0101; req_v[1] = 1'b1; cyc();
    `CHK({acc[1], len_err[1]}, 2'h3)
    rx_len[1] = 13'h0101; len[1] = 13'h0100; cyc();
    `CHK({acc[1], len_err[1]}, 2'h0)
    rx_v[1] = 1'b0; req_v[1] = 1'b0;
    $display("test payload done");
    wreg(2'h0, 16'h0004); err[0] = 3'h6; cyc();
    `CHK({rep_ur[0], rep_fat[0]}, 2'h1)
    err[0] = 3'h0; wreg(2'h0, 16'h0008); err[0] = 3'h6; cyc();
    `CHK({rep_ur[0], rep_fat[0]}, 2'h2)
    err[0] = 3'h1; cyc(); `CHK(rep_fat[0], 1'b1)
    err[0] = 3'h0;
    $display("test errors done");
    give_verdict();
  end
endmodule
`default_nettype wire
